// ### verilog/ttpc_pkg.sv
`default_nettype none

package ttpc_pkg;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned PRIMARY_WIDTH = 8;
  localparam int unsigned AUX_WIDTH     = 4;
  localparam int unsigned COUNT_WIDTH   = 2;
  localparam int unsigned SYNC_STAGES   = 2;

  // counter comes out of reset at 3; bridge leg A comes on at the first clock, with no count needed
  localparam logic [1:0] COUNT_RESET = 2'h3;
  localparam logic [1:0] COUNT_POL_A = 2'h3;
  localparam logic [1:0] COUNT_POL_B = 2'h1;

  typedef logic [COUNT_WIDTH-1:0] ttpc_count_t;

endpackage : ttpc_pkg

`default_nettype wire

// ### verilog/ttpc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// two-stage level synchroniser, one bit per lane
// ---------------------------------------------------------------
module ttpc_sync
  import ttpc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ttpc_sync_state_t;

  ttpc_sync_state_t state_r;
  ttpc_sync_state_t state_nxt;

  always_comb begin
    state_nxt        = state_r;
    state_nxt.meta   = async_in;
    // first stage feeds only the second stage
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stable;

endmodule // ttpc_sync

`default_nettype wire

// ### verilog/ttpc_controller.sv
// Function
// - OR all twelve trigger inputs together.
// - trigger decrements two-bit counter each clock, wrapping.
// - bridge enabled only at counts 1, 3.
// - even counts keep counting without trigger.
// - count value shown on two count outputs.
// - counter enable high while counter advances.
// - counter enable low once resting odd.
// - 3 gives A high; 1 gives B high.
// - trigger seen falls at once without clock.
// - trigger drives trigger seen and enable high.
// - error input rising edge latches error flag.
// - error forces count and bridge outputs low.
// - error disables bridge regardless of trigger.
// - reset clears error, disables counter, bridge.
// - oscillator output is inverse of input.
`timescale 1ns/1ps
`default_nettype none

module ttpc_controller
  import ttpc_pkg::*;
(
  // clock and reset
  input  wire logic                     clock_in,
  input  wire logic                     rst_n_in,
  // trigger inputs from mismatch detectors
  input  wire logic [PRIMARY_WIDTH-1:0] primary_trigger_inputs_in,
  input  wire logic [AUX_WIDTH-1:0]     auxiliary_trigger_inputs_in,
  // error request
  input  wire logic                     error_request_input_in,
  // oscillator
  input  wire logic                     oscillator_input_in,
  output logic                          oscillator_output_out,
  // count and bridge control
  output logic                          count_bit_low_out,
  output logic                          count_bit_high_out,
  output logic                          bridge_polarity_a_out,
  output logic                          bridge_polarity_b_out,
  // status
  output logic                          trigger_seen_out,
  output logic                          constant_high_out,
  output logic                          counter_enable_flag_out,
  output logic                          error_flag_out
);

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_WIDTH = PRIMARY_WIDTH + AUX_WIDTH + 1;

  logic [SYNC_WIDTH-1:0] raw_inputs;
  logic [SYNC_WIDTH-1:0] synced_inputs;
  logic                  trigger_synced;
  logic                  error_synced;
  logic                  trigger_raw;

  // error rides on the top lane of the same synchroniser
  assign raw_inputs = {error_request_input_in, auxiliary_trigger_inputs_in,
                       primary_trigger_inputs_in};

  ttpc_sync #(
    .WIDTH (SYNC_WIDTH)
  ) u_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in (raw_inputs),
    .sync_out (synced_inputs)
  );

  assign error_synced = synced_inputs[SYNC_WIDTH-1];

  // ---------------------------------------------------------------
  // trigger combine
  // ---------------------------------------------------------------
  localparam int unsigned LANES = PRIMARY_WIDTH + AUX_WIDTH;

  // running or per lane; raw copy only feeds the trigger-seen clear
  logic [LANES-1:0] any_raw;
  logic [LANES-1:0] any_sync;

  for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
    if (lane == 0) begin : g_first
      assign any_raw[lane]  = raw_inputs[lane];
      assign any_sync[lane] = synced_inputs[lane];
    end else begin : g_next
      assign any_raw[lane]  = any_raw[lane-1] | raw_inputs[lane];
      assign any_sync[lane] = any_sync[lane-1] | synced_inputs[lane];
    end
  end

  assign trigger_raw    = any_raw[LANES-1];
  assign trigger_synced = any_sync[LANES-1];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ttpc_count_t count;
    logic        error;
    logic        error_prev;
    logic        count_low;
    logic        count_high;
    logic        pol_a;
    logic        pol_b;
    logic        enable;
    logic        osc;
    logic        tie_high;
  } ttpc_state_t;

  ttpc_state_t state_r;
  ttpc_state_t state_nxt;
  logic        advance;
  logic        trigger_seen_r;
  logic [1:0]  bridge_legs;

  // ---------------------------------------------------------------
  // reset value
  // ---------------------------------------------------------------
  // tie-high pin comes from a flop as well, so every pin is registered
  localparam ttpc_state_t STATE_RESET = '{
    count:    COUNT_RESET,
    tie_high: 1'b1,
    default:  1'b0
  };

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic ttpc_is_even(input ttpc_count_t c);
    return ~c[0];
  endfunction

  // bridge legs {a, b}; both legs off on even counts
  function automatic logic [1:0] ttpc_bridge(input ttpc_count_t c);
    logic [1:0] legs;
    legs = 2'h0;
    if (c == COUNT_POL_A) begin
      legs = 2'h2;
    end else if (c == COUNT_POL_B) begin
      legs = 2'h1;
    end
    return legs;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // even counts step on by themselves, so the count rests there only once an error is latched
  assign advance = trigger_synced | ttpc_is_even(state_r.count);

  always_comb begin
    state_nxt            = state_r;
    state_nxt.tie_high   = 1'b1;
    // error: rising edge of the synchronised request, kept until reset
    state_nxt.error_prev = error_synced;
    if (error_synced && !state_r.error_prev) begin
      state_nxt.error = 1'b1;
    end
    // count freezes once an error is latched
    if (advance && !state_r.error) begin
      state_nxt.count = state_r.count - 2'h1;
    end
    // flags
    state_nxt.enable     = advance & ~state_nxt.error;
    state_nxt.count_low  = state_nxt.count[0] & ~state_nxt.error;
    state_nxt.count_high = state_nxt.count[1] & ~state_nxt.error;
    // bridge off on even counts avoids shoot-through in the fets
    bridge_legs          = ttpc_bridge(state_nxt.count) & {2{~state_nxt.error}};
    state_nxt.pol_a      = bridge_legs[1];
    state_nxt.pol_b      = bridge_legs[0];
    state_nxt.osc        = ~oscillator_input_in;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= STATE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // trigger seen: set on clock, cleared asynchronously
  // ---------------------------------------------------------------
  // one async clear for reset and trigger drop keeps a single control pin
  logic seen_clear_n;

  assign seen_clear_n = rst_n_in & trigger_raw;

  // falls the moment all triggers drop, no clock needed
  always_ff @(posedge clock_in or negedge seen_clear_n) begin
    if (!seen_clear_n) begin
      trigger_seen_r <= 1'b0;
    end else begin
      trigger_seen_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // oscillator is one flop delayed; real ring oscillation needs the pad path
  assign oscillator_output_out   = state_r.osc;
  // count and bridge
  assign count_bit_low_out       = state_r.count_low;
  assign count_bit_high_out      = state_r.count_high;
  assign bridge_polarity_a_out   = state_r.pol_a;
  assign bridge_polarity_b_out   = state_r.pol_b;
  // status
  assign trigger_seen_out        = trigger_seen_r;
  assign constant_high_out       = state_r.tie_high;
  assign counter_enable_flag_out = state_r.enable;
  assign error_flag_out          = state_r.error;

endmodule // ttpc_controller

`default_nettype wire

// ### tb/ttpc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ttpc_partner #(
  parameter int LIMIT = 24
) (
  // far side
  input  wire logic clock_in,
  input  wire logic enable_in,
  input  wire logic osc_in,
  output logic      error_req_out,
  output logic      osc_feed_out
);
  int held;
  // rc delay: a stuck enable charges past the threshold
  always @(posedge clock_in) held <= enable_in ? held + 1 : 0;
  assign error_req_out = held >= LIMIT;
  // rc loop settles after the falling edge, 2 ns before the next rising edge
  assign #3 osc_feed_out = osc_in;
endmodule // ttpc_partner
`default_nettype wire

// ### tb/ttpc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ttpc_asserts
  import ttpc_pkg::*;
(
  // inputs
  input wire logic                     clock_in,
  input wire logic                     rst_n_in,
  input wire logic [PRIMARY_WIDTH-1:0] primary_trigger_inputs_in,
  input wire logic [AUX_WIDTH-1:0]     auxiliary_trigger_inputs_in,
  input wire logic                     error_request_input_in,
  input wire logic                     oscillator_input_in,
  // outputs
  input wire logic                     oscillator_output_out,
  input wire logic                     count_bit_low_out,
  input wire logic                     count_bit_high_out,
  input wire logic                     bridge_polarity_a_out,
  input wire logic                     bridge_polarity_b_out,
  input wire logic                     trigger_seen_out,
  input wire logic                     counter_enable_flag_out,
  input wire logic                     error_flag_out
);
  logic [1:0] cnt;
  logic [1:0] up_r;
  logic       trg;
  logic       ok;
  assign cnt = {count_bit_high_out, count_bit_low_out};
  assign trg = |{primary_trigger_inputs_in, auxiliary_trigger_inputs_in};
  // skip the cycles where outputs still show reset values
  assign ok  = up_r == 2'h3 && !error_flag_out;
  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_pol_map: assert property (bridge_polarity_a_out |-> cnt == COUNT_POL_A)
    else $error("pol a off count");
  a_even_off: assert property (ok && !cnt[0] |-> !(bridge_polarity_a_out | bridge_polarity_b_out))
    else $error("bridge on even");
  a_count_step: assert property (ok && $changed(cnt) |-> cnt == $past(cnt) - 2'h1)
    else $error("bad step");
  a_even_moves: assert property (ok && !cnt[0] |=> error_flag_out || $changed(cnt))
    else $error("even rest");
  a_rest_idle: assert property (ok && cnt[0] && $stable(cnt) |-> !counter_enable_flag_out)
    else $error("enable at rest");
  a_seen_drop: assert property (!trg |-> !trigger_seen_out)
    else $error("seen stuck");
  a_err_latch: assert property ($rose(error_request_input_in) |-> ##[1:4] error_flag_out)
    else $error("no latch");
  a_err_quiet: assert property (error_flag_out && $past(error_flag_out)
    |-> !(|{cnt, bridge_polarity_a_out, bridge_polarity_b_out}))
    else $error("outputs live");
  a_osc_inv: assert property ($past(rst_n_in)
    |-> oscillator_output_out == !$past(oscillator_input_in))
    else $error("osc not inverse");
  a_pol_b_map: assert property (bridge_polarity_b_out |-> cnt == COUNT_POL_B)
    else $error("pol b off count");
  a_move_en: assert property (ok && $changed(cnt) |-> counter_enable_flag_out)
    else $error("step without enable");
  c_err: cover property (error_flag_out);
  c_rest_b: cover property (ok && cnt == COUNT_POL_B);
  c_run: cover property (counter_enable_flag_out);
endmodule // ttpc_asserts
bind ttpc_controller ttpc_asserts chk (.*);
`default_nettype wire

// ### tb/test_ttpc_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_ttpc_controller;
  logic        clock_in, rst_n_in, err_req, osc_i, osc_o;
  logic        lo, hi, pa, pb, seen, vcc, en, err;
  logic [11:0] trig;
  logic [7:0]  st;
  int          n_mismatch, n_tests;
  int          n;
  logic [1:0]  cnt_e;
  assign st = {vcc, hi, lo, pa, pb, seen, en, err};
  ttpc_controller uut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .primary_trigger_inputs_in(trig[7:0]), .auxiliary_trigger_inputs_in(trig[11:8]),
    .error_request_input_in(err_req), .oscillator_input_in(osc_i),
    .oscillator_output_out(osc_o), .count_bit_low_out(lo), .count_bit_high_out(hi),
    .bridge_polarity_a_out(pa), .bridge_polarity_b_out(pb), .trigger_seen_out(seen),
    .constant_high_out(vcc), .counter_enable_flag_out(en), .error_flag_out(err));
  ttpc_partner far (.clock_in(clock_in), .enable_in(en), .osc_in(osc_o),
    .error_req_out(err_req), .osc_feed_out(osc_i));
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    trig = 12'h000;
    rst_n_in = 1'b0;
    tick(6);
    rst_n_in = 1'b1;
    tick(4);
    chk("rest", 8'hf0, st);
    cnt_e = ttpc_pkg::COUNT_RESET;
    for (int i = 0; i < 12; i++) begin
      n = 4 + i % 4;
      trig = 12'h001 << i;
      tick(n);
      chk("run", 8'h06, st & 8'h06);
      chk("osc", 8'h01, {7'h0, osc_o ^ osc_i});
      trig = 12'h000;
      #1;
      chk("drop", 8'h00, st & 8'h04);
      tick(8);
      // one step per triggered clock, one more if that lands even
      cnt_e = cnt_e - 2'(n);
      if (!cnt_e[0]) cnt_e = cnt_e - 2'h1;
      chk("idle", {1'b1, cnt_e, cnt_e == 2'h3, cnt_e == 2'h1, 3'h0}, st);
    end
    // held trigger lets the partner rc delay raise the error input
    trig = 12'h800;
    tick(40);
    chk("err", 8'h85, st);
    trig = 12'h000;
    tick(2);
    rst_n_in = 1'b0;
    tick(2);
    chk("rst", 8'h80, st);
    rst_n_in = 1'b1;
    tick(4);
    chk("back", 8'hf0, st);
    end_sim();
  end
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
endmodule // test_ttpc_controller
`default_nettype wire
